/* File: verilog/mac_status_irq.sv */
// Purpose: Receive status, interrupt status, enable, disable and mask registers of a MAC DMA.
// Assumes: All event inputs are one-cycle pulses on pclk, except wake_event from a pin.
// Notes: APB slave with no wait states; unmapped addresses answer pslverr.
// Behaviour
// - Receive status bits 2,1,0; write-one clears.
// - Set no-buffer flag on processor-owned descriptor.
// - After failed fetch, refetch at each frame start.
// - No-buffer flag set again on every failure.
// - Set frame-stored flag when frame reaches memory.
// - Set overrun flag on late grant or error.
// - Recover the in-use receive buffer on overrun.
// - Bit 0 on PHY management done; read clears.
// - Bit 1 on frame stored in memory.
// - Bit 2 on receive descriptor used bit.
// - Bit 3 on transmit descriptor used bit.
// - Bit 4 on any transmit underrun cause.
// - Bit 6 on transmit buffers exhausted mid-frame.
// - Bit 7 on each transmitted frame.
// - Bit 10 when receive overrun flag sets.
// - Bit 11 on any DMA bus error.
// - Bit 12 on valid pause frame received.
// - Bit 13 when pause countdown reaches zero.
// - Bit 14 on wake event, clockless capture.
// - Enable write of one enables source.
// - Disable write of one disables source.
// - Mask register reads enable state per source.
// - Pause countdown decrements every 512 bit times.
`timescale 1ns/10ps

module mac_status_irq
    import mac_irq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_buf_needed,
    input wire logic rx_frame_start,
    input wire logic rx_desc_valid,
    input wire logic rx_desc_cpu_owned,
    output logic rx_desc_fetch,
    input wire logic rx_frame_stored,
    input wire logic rx_grant_late,
    input wire logic rx_bus_error,
    output logic rx_buf_recover,
    input wire logic phy_mgmt_done,
    input wire logic tx_used_desc,
    input wire logic tx_data_late,
    input wire logic tx_bus_error,
    input wire logic tx_used_midframe,
    input wire logic tx_queue_ptr_written,
    input wire logic tx_midframe_exhaust,
    input wire logic tx_frame_done,
    input wire logic tx_retry_limit,
    input wire logic pause_frame_valid,
    input wire logic [PAUSE_W-1:0] pause_frame_time,
    input wire logic wake_event,
    output logic [PAUSE_W-1:0] pause_countdown,
    output logic irq
);

    // ************************************************************
    // APB decode.
    // ************************************************************

    // Address hits and access strobes; writes and read side effects occur in the access phase.
    wire logic hit_rx_status = (paddr == ADDR_RX_STATUS);
    wire logic hit_irq_status = (paddr == ADDR_IRQ_STATUS);
    wire logic hit_irq_enable = (paddr == ADDR_IRQ_ENABLE);
    wire logic hit_irq_disable = (paddr == ADDR_IRQ_DISABLE);
    wire logic hit_irq_mask = (paddr == ADDR_IRQ_MASK);
    wire logic hit_pause = (paddr == ADDR_PAUSE_TIME);
    wire logic hit_any = hit_rx_status | hit_irq_status | hit_irq_enable | hit_irq_disable
        | hit_irq_mask | hit_pause;
    wire logic setup_phase = psel & ~penable;
    wire logic access_phase = psel & penable;
    wire logic wr_access = access_phase & pwrite;
    wire logic rd_access = access_phase & ~pwrite;

    // Zero wait states; error only for unmapped addresses.
    assign pready = 1'b1;
    assign pslverr = access_phase & ~hit_any;

    // ************************************************************
    // Receive buffer fetch sequencing.
    // ************************************************************

    rx_fetch_state_t rx_state;
    rx_fetch_state_t next_rx_state;
    wire logic fetch_failed = (rx_state == RX_FETCH) & rx_desc_valid & rx_desc_cpu_owned;
    wire logic fetch_ok = (rx_state == RX_FETCH) & rx_desc_valid & ~rx_desc_cpu_owned;

    // A failed fetch parks the DMA until the next frame begins, then it tries again.
    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            RX_HAVE_BUF: begin
                if (rx_buf_needed) begin
                    next_rx_state = RX_FETCH;
                end
            end
            RX_FETCH: begin
                if (fetch_failed) begin
                    next_rx_state = RX_NO_BUF;
                end else if (fetch_ok) begin
                    next_rx_state = RX_HAVE_BUF;
                end
            end
            RX_NO_BUF: begin
                if (rx_frame_start) begin
                    next_rx_state = RX_FETCH;
                end
            end
            default: begin
                next_rx_state = RX_HAVE_BUF;
            end
        endcase
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= RX_HAVE_BUF;
        end else begin
            rx_state <= next_rx_state;
        end
    end

    // The fetch request stands for as long as the fetch is outstanding.
    assign rx_desc_fetch = (rx_state == RX_FETCH);

    // Overrun hands the buffer back so the DMA can reuse it for the next frame.
    wire logic rx_overrun = rx_grant_late | rx_bus_error;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_recover <= 1'b0;
        end else begin
            rx_buf_recover <= rx_overrun;
        end
    end

    // ************************************************************
    // Pause countdown.
    // ************************************************************

    // Divider producing one tick per 512 bit times.
    logic [PAUSE_DIV_W-1:0] pause_div;
    wire logic pause_tick = (pause_div == PAUSE_DIV_W'(PAUSE_TICK_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_div <= '0;
        end else if (pause_tick) begin
            pause_div <= '0;
        end else begin
            pause_div <= pause_div + 1'b1;
        end
    end

    // A software write or a received pause frame reloads; otherwise count down to zero.
    wire logic pause_load_sw = wr_access & hit_pause;
    wire logic pause_decrement = pause_tick & (pause_countdown != '0);
    wire logic pause_hits_zero = pause_decrement & (pause_countdown == PAUSE_W'(1))
        & ~pause_load_sw & ~pause_frame_valid;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_countdown <= PAUSE_RESET;
        end else if (pause_load_sw) begin
            pause_countdown <= pwdata[PAUSE_W-1:0];
        end else if (pause_frame_valid) begin
            pause_countdown <= pause_frame_time;
        end else if (pause_decrement) begin
            pause_countdown <= pause_countdown - 1'b1;
        end
    end

    // ************************************************************
    // Wake event capture.
    // ************************************************************

    // The toggle runs on the wake pin itself, so it catches an event while pclk is stopped.
    logic wake_toggle;

    always_ff @(posedge wake_event or negedge presetn) begin
        if (!presetn) begin
            wake_toggle <= 1'b0;
        end else begin
            wake_toggle <= ~wake_toggle;
        end
    end

    // Three-stage synchroniser; a change counts when stages two and three differ.
    logic wake_sync1;
    logic wake_sync2;
    logic wake_sync3;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_sync1 <= 1'b0;
            wake_sync2 <= 1'b0;
            wake_sync3 <= 1'b0;
        end else begin
            wake_sync1 <= wake_toggle;
            wake_sync2 <= wake_sync1;
            wake_sync3 <= wake_sync2;
        end
    end

    wire logic wake_seen = wake_sync2 ^ wake_sync3;

    // ************************************************************
    // Receive status register.
    // ************************************************************

    logic [RX_STATUS_W-1:0] rx_status;
    logic [RX_STATUS_W-1:0] rx_status_set;
    wire logic [RX_STATUS_W-1:0] rx_status_clr =
        (wr_access & hit_rx_status) ? pwdata[RX_STATUS_W-1:0] : '0;

    // Hardware sets only; a write can clear but never set.
    always_comb begin
        rx_status_set = '0;
        rx_status_set[RS_NO_BUFFER] = fetch_failed;
        rx_status_set[RS_FRAME_STORED] = rx_frame_stored;
        rx_status_set[RS_OVERRUN] = rx_overrun;
    end

    sticky_flags #(
        .WIDTH(RX_STATUS_W),
        .RESET_VALUE(RX_STATUS_RESET)
    ) u_rx_status (
        .pclk(pclk),
        .presetn(presetn),
        .set(rx_status_set),
        .clr(rx_status_clr),
        .flags(rx_status)
    );

    // ************************************************************
    // Interrupt status register.
    // ************************************************************

    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_set;

    // Only bits that were captured into prdata are cleared, so an event arriving
    // between setup and access phases survives the read.
    wire logic [IRQ_W-1:0] irq_clr = (rd_access & hit_irq_status) ? prdata[IRQ_W-1:0] : '0;

    // Source mapping onto the shared bit layout.
    always_comb begin
        irq_set = '0;
        irq_set[IB_PHY_DONE] = phy_mgmt_done;
        irq_set[IB_RX_COMPLETE] = rx_frame_stored;
        irq_set[IB_RX_USED] = fetch_failed;
        irq_set[IB_TX_USED] = tx_used_desc;
        irq_set[IB_TX_UNDERRUN] = tx_data_late | tx_bus_error | tx_used_midframe
            | tx_queue_ptr_written;
        irq_set[IB_RETRY_LIMIT] = tx_retry_limit;
        irq_set[IB_TX_EXHAUST] = tx_midframe_exhaust;
        irq_set[IB_TX_COMPLETE] = tx_frame_done;
        irq_set[IB_RX_OVERRUN] = rx_overrun;
        irq_set[IB_BUS_ERROR] = rx_bus_error | tx_bus_error;
        irq_set[IB_PAUSE_RX] = pause_frame_valid;
        irq_set[IB_PAUSE_ZERO] = pause_hits_zero;
        irq_set[IB_WAKE] = wake_seen;
    end

    sticky_flags #(
        .WIDTH(IRQ_W),
        .RESET_VALUE(IRQ_STATUS_RESET)
    ) u_irq_status (
        .pclk(pclk),
        .presetn(presetn),
        .set(irq_set),
        .clr(irq_clr),
        .flags(irq_status)
    );

    // ************************************************************
    // Interrupt enable state and output.
    // ************************************************************

    logic [IRQ_W-1:0] irq_mask;
    wire logic [IRQ_W-1:0] en_bits =
        (wr_access & hit_irq_enable) ? (pwdata[IRQ_W-1:0] & IRQ_IMPL_MASK) : '0;
    wire logic [IRQ_W-1:0] dis_bits =
        (wr_access & hit_irq_disable) ? (pwdata[IRQ_W-1:0] & IRQ_IMPL_MASK) : '0;

    // Ones set or clear individual sources; zeros leave them alone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= IRQ_MASK_RESET;
        end else begin
            irq_mask <= (irq_mask | en_bits) & ~dis_bits;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ************************************************************
    // Read data.
    // ************************************************************

    // Read data is sampled in the setup phase and held through the access phase.
    logic [31:0] read_mux;

    always_comb begin
        read_mux = 32'h00000000;
        if (hit_rx_status) begin
            read_mux[RX_STATUS_W-1:0] = rx_status;
        end else if (hit_irq_status) begin
            read_mux[IRQ_W-1:0] = irq_status;
        end else if (hit_irq_mask) begin
            read_mux[IRQ_W-1:0] = irq_mask;
        end else if (hit_pause) begin
            read_mux[PAUSE_W-1:0] = pause_countdown;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase & ~pwrite) begin
            prdata <= read_mux;
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************

    a_bna_on_fail: assert property (@(posedge pclk) disable iff (!presetn)
        fetch_failed |=> rx_status[RS_NO_BUFFER] && irq_status[IB_RX_USED])
        else $error("failed fetch did not raise no-buffer flags");

    a_refetch_frame: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_state == RX_NO_BUF) && rx_frame_start |=> rx_desc_fetch)
        else $error("no refetch at frame start");

    a_parked_no_fetch: assert property (@(posedge pclk) disable iff (!presetn)
        fetch_failed |=> !rx_desc_fetch ##0 (rx_state == RX_NO_BUF))
        else $error("fetch did not park after failure");

    a_overrun_recover: assert property (@(posedge pclk) disable iff (!presetn)
        rx_overrun |=> rx_buf_recover && rx_status[RS_OVERRUN] && irq_status[IB_RX_OVERRUN])
        else $error("overrun did not recover buffer or set flags");

    a_rs_write_noset: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_status_set == '0) |=> (rx_status & ~$past(rx_status)) == '0)
        else $error("receive status bit set without an event");

    a_isr_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rd_access && hit_irq_status && (irq_set == '0) |=>
        (irq_status & $past(prdata[IRQ_W-1:0])) == '0)
        else $error("read bits not cleared");

    a_mask_enable: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && hit_irq_enable |=> (($past(pwdata[IRQ_W-1:0]) & IRQ_IMPL_MASK) & ~irq_mask) == '0)
        else $error("enable write did not enable");

    a_mask_disable: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && hit_irq_disable |=> (irq_mask & $past(pwdata[IRQ_W-1:0])) == '0)
        else $error("disable write did not disable");

    a_pause_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pause_hits_zero |=> (pause_countdown == '0) && irq_status[IB_PAUSE_ZERO])
        else $error("pause zero not flagged");

    a_pause_period: assert property (@(posedge pclk) disable iff (!presetn)
        pause_tick |=> !pause_tick [*8])
        else $error("pause tick too frequent");

    a_irq_enabled: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && hit_irq_enable && ((pwdata[IRQ_W-1:0] & irq_status) != '0)
        && (irq_clr == '0) |=> irq)
        else $error("enabled pending source gave no interrupt");

endmodule

/* File: verilog/mac_irq_pkg.sv */
// Purpose: Shared constants for the MAC receive status and interrupt status block.
// Assumes: 32-bit APB data, 100 MHz pclk, 100 Mb/s line rate for the pause quantum.
// Notes: Offsets are the full byte addresses of the registers.
package mac_irq_pkg;

    // ************************************************************
    // Register byte addresses.
    // ************************************************************
    localparam logic [31:0] ADDR_RX_STATUS = 32'hFFFBC020;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'hFFFBC024;
    localparam logic [31:0] ADDR_IRQ_ENABLE = 32'hFFFBC028;
    localparam logic [31:0] ADDR_IRQ_DISABLE = 32'hFFFBC02C;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'hFFFBC030;
    localparam logic [31:0] ADDR_PAUSE_TIME = 32'hFFFBC038;

    // ************************************************************
    // Field positions and widths.
    // ************************************************************
    localparam int RX_STATUS_W = 3;
    localparam int IRQ_W = 15;
    localparam int PAUSE_W = 16;
    localparam int RS_NO_BUFFER = 0;
    localparam int RS_FRAME_STORED = 1;
    localparam int RS_OVERRUN = 2;
    localparam int IB_PHY_DONE = 0;
    localparam int IB_RX_COMPLETE = 1;
    localparam int IB_RX_USED = 2;
    localparam int IB_TX_USED = 3;
    localparam int IB_TX_UNDERRUN = 4;
    localparam int IB_RETRY_LIMIT = 5;
    localparam int IB_TX_EXHAUST = 6;
    localparam int IB_TX_COMPLETE = 7;
    localparam int IB_RX_OVERRUN = 10;
    localparam int IB_BUS_ERROR = 11;
    localparam int IB_PAUSE_RX = 12;
    localparam int IB_PAUSE_ZERO = 13;
    localparam int IB_WAKE = 14;

    // Implemented source bits; 8 and 9 are reserved and read as zero.
    localparam logic [IRQ_W-1:0] IRQ_IMPL_MASK = 15'h7CFF;

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [RX_STATUS_W-1:0] RX_STATUS_RESET = 3'h0;
    localparam logic [IRQ_W-1:0] IRQ_STATUS_RESET = 15'h0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 15'h0000;
    localparam logic [PAUSE_W-1:0] PAUSE_RESET = 16'h0000;

    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS = 10;
    localparam int PAUSE_QUANTUM_BITS = 512;
    localparam int PAUSE_TICK_CYCLES = PAUSE_QUANTUM_BITS * BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int PAUSE_DIV_W = 10;

    // Receive buffer fetch states.
    typedef enum logic [1:0] {RX_HAVE_BUF, RX_FETCH, RX_NO_BUF} rx_fetch_state_t;

endpackage

/* File: verilog/sticky_flags.sv */
// Purpose: A row of sticky flags that hardware sets and software clears.
// Assumes: set and clr are single-cycle qualifiers on pclk.
// Notes: A set in the same cycle as a clear always wins.
`timescale 1ns/10ps

module sticky_flags #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] flags
);

    // Clear first, then set, so no event is lost under a clear.
    wire logic [WIDTH-1:0] next_flags = (flags & ~clr) | set;

    // Flag storage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= RESET_VALUE;
        end else begin
            flags <= next_flags;
        end
    end

endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the MAC receive status and interrupt status block.
// Assumes: Zero-wait APB slave, event inputs are one-cycle pulses on pclk.
// Notes: Ordinary event cases sit in a table; fetch, mask, pause and wake are hand-written.
`timescale 1ns/10ps

module testbench
    import mac_irq_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, cpu_owned, wake;
    logic [31:0] paddr, pwdata, prdata, d;
    logic pready, pslverr, fetch, recover, irq, e;
    logic [15:0] ev;
    logic [PAUSE_W-1:0] pcount;
    logic [14:0] exp_isr [13];
    logic [2:0] exp_rs [13];
    int bad_count, tests_run, n;

    mac_status_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_buf_needed(ev[13]), .rx_frame_start(ev[14]),
        .rx_desc_valid(ev[15]), .rx_desc_cpu_owned(cpu_owned), .rx_desc_fetch(fetch),
        .rx_frame_stored(ev[1]), .rx_grant_late(ev[10]), .rx_bus_error(ev[11]),
        .rx_buf_recover(recover), .phy_mgmt_done(ev[0]), .tx_used_desc(ev[2]),
        .tx_data_late(ev[3]), .tx_bus_error(ev[4]), .tx_used_midframe(ev[5]),
        .tx_queue_ptr_written(ev[6]), .tx_midframe_exhaust(ev[8]), .tx_frame_done(ev[9]),
        .tx_retry_limit(ev[7]), .pause_frame_valid(ev[12]), .pause_frame_time(16'h0000),
        .wake_event(wake), .pause_countdown(pcount), .irq(irq));

    // ************************************************************
    // Clock, checking and bus tasks.
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; only the watchdog ends the wait on a slave that never answers.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, exp, d);
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
    endtask

    task automatic wait_fetch(input logic exp);
        for (int k = 0; k < 10 && fetch !== exp; k++) @(posedge pclk);
        chk("fetch", {31'h0, exp}, {31'h0, fetch});
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The whole run needs under two thousand cycles; this is a generous ceiling.
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        $display("watchdog expired");
        finish_test();
    end

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        {presetn, psel, penable, pwrite, cpu_owned, wake} = 6'h00;
        {paddr, pwdata, ev} = '0;
        exp_isr = '{15'h0001, 15'h0002, 15'h0008, 15'h0010, 15'h0810, 15'h0010, 15'h0010,
            15'h0020, 15'h0040, 15'h0080, 15'h0400, 15'h0C00, 15'h1000};
        exp_rs = '{3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h4, 3'h0};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_RX_STATUS, 32'h0, "rs reset");
        chk("pslverr mapped", 32'h0, {31'h0, e});
        rd(ADDR_IRQ_STATUS, 32'h0, "isr reset");
        rd(ADDR_IRQ_MASK, 32'h0, "mask reset");
        // Each row fires one event; a write of zero must keep a flag, a write of ones clears.
        for (int i = 0; i < 13; i++) begin
            pulse(i);
            rd(ADDR_IRQ_STATUS, {17'h0, exp_isr[i]}, "isr");
            rd(ADDR_IRQ_STATUS, 32'h0, "isr after read");
            apb(1'b1, ADDR_RX_STATUS, 32'h0);
            rd(ADDR_RX_STATUS, {29'h0, exp_rs[i]}, "rs");
            apb(1'b1, ADDR_RX_STATUS, 32'hFFFFFFFF);
            rd(ADDR_RX_STATUS, 32'h0, "rs cleared");
            chk("irq masked", 32'h0, {31'h0, irq});
        end
        pulse(10);
        #1 chk("recover", 32'h1, {31'h0, recover});
        apb(1'b1, ADDR_RX_STATUS, 32'h0000_0007);
        rd(ADDR_IRQ_STATUS, 32'h0000_0400, "overrun isr");
        rd(32'hFFFBC034, 32'h0, "unmapped");
        chk("pslverr", 32'h1, {31'h0, e});
        // A failed fetch parks the DMA; every frame start retries and every failure flags.
        pulse(13);
        wait_fetch(1'b1);
        cpu_owned <= 1'b1;
        pulse(15);
        wait_fetch(1'b0);
        rd(ADDR_RX_STATUS, 32'h1, "no buffer");
        rd(ADDR_IRQ_STATUS, 32'h4, "rx used isr");
        apb(1'b1, ADDR_RX_STATUS, 32'h1);
        pulse(14);
        wait_fetch(1'b1);
        pulse(15);
        wait_fetch(1'b0);
        rd(ADDR_RX_STATUS, 32'h1, "no buffer again");
        rd(ADDR_IRQ_STATUS, 32'h4, "rx used isr again");
        apb(1'b1, ADDR_RX_STATUS, 32'h1);
        cpu_owned <= 1'b0;
        pulse(14);
        wait_fetch(1'b1);
        pulse(15);
        wait_fetch(1'b0);
        rd(ADDR_RX_STATUS, 32'h0, "good buffer");
        rd(ADDR_IRQ_STATUS, 32'h0, "isr clean");
        // Enable and disable act only on ones; reserved bits never show in the mask.
        apb(1'b1, ADDR_IRQ_ENABLE, 32'hFFFFFFFF);
        rd(ADDR_IRQ_MASK, 32'h0000_7CFF, "mask all");
        chk("irq idle", 32'h0, {31'h0, irq});
        pulse(9);
        #1 chk("irq up", 32'h1, {31'h0, irq});
        apb(1'b1, ADDR_IRQ_DISABLE, 32'h0000_0080);
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
        apb(1'b1, ADDR_IRQ_DISABLE, 32'h0);
        rd(ADDR_IRQ_MASK, 32'h0000_7C7F, "mask less");
        chk("irq down", 32'h0, {31'h0, irq});
        // Enabling a source that is already pending must raise the line at once.
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0080);
        #1 chk("irq again", 32'h1, {31'h0, irq});
        rd(ADDR_IRQ_STATUS, 32'h0080, "tx done");
        // Wake is captured without pclk, then resynchronised; allow the sync latency.
        wake <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(ADDR_IRQ_STATUS, 32'h4000, "wake");
        #1 chk("irq wake", 32'h0, {31'h0, irq});
        // Pause countdown steps once per quantum and flags on reaching zero.
        apb(1'b1, ADDR_PAUSE_TIME, 32'h2);
        for (n = 0; n < 600 && pcount !== 16'h0001; n++) @(posedge pclk);
        for (n = 0; n < 600 && pcount !== 16'h0000; n++) @(posedge pclk);
        chk("pause step", PAUSE_TICK_CYCLES, n);
        rd(ADDR_IRQ_STATUS, 32'h2000, "pause zero");
        // A reset in mid-run must return the enable state to all disabled.
        presetn <= 1'b0;
        @(posedge pclk);
        chk("irq in reset", 32'h0, {31'h0, irq});
        presetn <= 1'b1;
        rd(ADDR_IRQ_MASK, 32'h0, "mask after reset");
        finish_test();
    end
endmodule
